// ===== shared/sync_irq_protect_consts.svh
// constants for the sync sampling, interrupt pin and protection block
// assumes: included by bare name, definitions only
`ifndef SYNC_IRQ_PROTECT_CONSTS_SVH
`define SYNC_IRQ_PROTECT_CONSTS_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ADDR_OFS_LO       8'h70
`define ADDR_OFS_HI       8'h71
`define ADDR_APPLIED_LO   8'h72
`define ADDR_APPLIED_HI   8'h73
`define ADDR_IRQ_STATUS   8'h60
`define ADDR_IRQ_MASK     8'h61
`define ADDR_SYNC_PHASE   8'h7B
`define ADDR_SYNC_MON     8'h7C
`define ADDR_INT_CFG      8'h7D
`define ADDR_PROT_KEY     8'h7E
// ------------------------------------------------------------
// reset values and key codes
// ------------------------------------------------------------
`define RST_SYNC_PHASE    8'h00
`define RST_SYNC_MON      8'h2B
`define RST_INT_CFG       8'h02
`define RST_PROT_KEY      8'h85
`define KEY_FULL          8'h85
`define KEY_SINGLE        8'h86
`define KEY_RELOCK        8'h84
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MON_CAL_BIT       7
`define INT_GPO_BIT       2
`define INT_TRI_BIT       1
`define INT_POL_BIT       0
`define EV_CAL_BIT        3
`define EV_BLOCK_BIT      4
// ------------------------------------------------------------
// timing: reference clock unit interval in system clocks
// ------------------------------------------------------------
`define CLK_PERIOD_NS     50
`define REF_PERIOD_NS     400
`define UI_CYCLES         (`REF_PERIOD_NS / `CLK_PERIOD_NS)
`define HALF_UI_CYCLES    (`UI_CYCLES / 2)
`define HIST_LEN          (3 * `HALF_UI_CYCLES + 1)
`endif

// ===== shared/sync_irq_protect_pkg.sv
// types shared by the sync sampling, interrupt and protection block
// assumes: compiled before any design file
package sync_irq_protect_pkg;
  // calibration routine steps
  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_DOWN,
    CAL_RESET,
    CAL_UP
  } cal_state_e;

  // one register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// ===== logic/sync_irq_protect_regs.sv
// sync input sampling, phase offset ramp/calibration, interrupt pin
// and write protection, reached over a plain register port.
// assumes: one 20 MHz clock, synchronous reset, sync pins asynchronous
`include "sync_irq_protect_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_irq_protect_regs (
  input  wire logic                               sys_clk,
  input  wire logic                               sys_rst,
  input  wire sync_irq_protect_pkg::reg_req_s     reg_req,
  output logic [7:0]                              rd_data,
  input  wire logic [2:0]                         sync_pin,
  output logic [2:0]                              sync_sampled,
  output logic [15:0]                             applied_offset,
  output logic                                    holdover,
  output logic                                    divider_reset,
  output logic                                    irq,
  output logic                                    irq_pin_out,
  output logic                                    irq_pin_oe
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]  sync_sampling_phase;
  logic [7:0]  sync_monitor_config;
  logic [7:0]  interrupt_pin_config;
  logic [7:0]  write_protection_key;
  logic [7:0]  irq_status;
  logic [7:0]  irq_mask;
  logic [15:0] ofs_target;
  logic [2:0]  sync_s1;
  logic [2:0]  sync_s2;
  logic [2:0]  sync_s3;
  logic [2:0]  sync_flt;
  logic [`HIST_LEN-1:0] hist [3];
  logic [3:0]  ref_cnt;
  logic        ref_tick;
  sync_irq_protect_pkg::cal_state_e cal_state;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // history tap for one offset code; nominal sits half a UI deep so
  // that "early" still has a real sample to look at
  function automatic logic [3:0] tap(input logic [1:0] code);
    case (code)
      2'b00:   tap = 4'(`HALF_UI_CYCLES);
      2'b01:   tap = 4'h0;
      2'b10:   tap = 4'(3 * `HALF_UI_CYCLES);
      default: tap = 4'(2 * `HALF_UI_CYCLES);
    endcase
  endfunction

  // one step of the ramp toward a goal
  function automatic logic [15:0] step(input logic [15:0] cur,
                                       input logic [15:0] goal);
    if (cur < goal) begin
      step = cur + 16'h0001;
    end else if (cur > goal) begin
      step = cur - 16'h0001;
    end else begin
      step = cur;
    end
  endfunction

  // read selection
  function automatic logic [7:0] rd_sel(input logic [7:0] a,
                                        input logic [15:0] tgt,
                                        input logic [15:0] app);
    case (a)
      `ADDR_OFS_LO:     rd_sel = tgt[7:0];
      `ADDR_OFS_HI:     rd_sel = tgt[15:8];
      `ADDR_APPLIED_LO: rd_sel = app[7:0];
      `ADDR_APPLIED_HI: rd_sel = app[15:8];
      default:          rd_sel = 8'h00;
    endcase
  endfunction

  // ------------------------------------------------------------
  // register port decode
  // ------------------------------------------------------------
  // the key register is always writable, otherwise nothing could unlock
  wire       key_sel    = reg_req.wr && (reg_req.addr == `ADDR_PROT_KEY);
  wire       unlocked   = (write_protection_key == `KEY_FULL) ||
                          (write_protection_key == `KEY_SINGLE);
  wire       wr_other   = reg_req.wr && !key_sel;
  wire       wr_ok      = wr_other && unlocked;
  wire       wr_blocked = wr_other && !unlocked;
  wire       hit_phase  = wr_ok && (reg_req.addr == `ADDR_SYNC_PHASE);
  wire       hit_mon    = wr_ok && (reg_req.addr == `ADDR_SYNC_MON);
  wire       hit_int    = wr_ok && (reg_req.addr == `ADDR_INT_CFG);
  wire       hit_stat   = wr_ok && (reg_req.addr == `ADDR_IRQ_STATUS);
  wire       hit_mask   = wr_ok && (reg_req.addr == `ADDR_IRQ_MASK);
  wire       hit_lo     = wr_ok && (reg_req.addr == `ADDR_OFS_LO);
  wire       hit_hi     = wr_ok && (reg_req.addr == `ADDR_OFS_HI);

  wire [7:0] rd_mux =
    (reg_req.addr == `ADDR_SYNC_PHASE) ? sync_sampling_phase  :
    (reg_req.addr == `ADDR_SYNC_MON)   ? sync_monitor_config  :
    (reg_req.addr == `ADDR_INT_CFG)    ? interrupt_pin_config :
    (reg_req.addr == `ADDR_PROT_KEY)   ? write_protection_key :
    (reg_req.addr == `ADDR_IRQ_STATUS) ? irq_status           :
    (reg_req.addr == `ADDR_IRQ_MASK)   ? irq_mask             :
    rd_sel(reg_req.addr, ofs_target, applied_offset);

  // ------------------------------------------------------------
  // calibration and ramp decode
  // ------------------------------------------------------------
  wire cal_idle   = (cal_state == sync_irq_protect_pkg::CAL_IDLE);
  wire cal_start  = hit_mon && reg_req.wdata[`MON_CAL_BIT] && cal_idle;
  wire cal_finish = (cal_state == sync_irq_protect_pkg::CAL_UP) &&
                    (applied_offset == ofs_target);
  wire [15:0] ramp_goal =
    (cal_state == sync_irq_protect_pkg::CAL_DOWN) ? 16'h0000 : ofs_target;
  // the ramp pauses for the one cycle in which the dividers restart
  wire        ramp_en   = ref_tick &&
                          (cal_state != sync_irq_protect_pkg::CAL_RESET);

  // ------------------------------------------------------------
  // sync sampling decode
  // ------------------------------------------------------------
  logic [2:0] next_sampled;
  logic [2:0] sync_fall;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      next_sampled[i] = hist[i][tap(sync_sampling_phase[2*i +: 2])];
    end
  end
  // a falling edge counts only at the reference tick, so an edge up to
  // half a UI either side of its slot lands in the same sample
  assign sync_fall = ref_tick ? (sync_sampled & ~next_sampled)
                              : 3'h0;

  // ------------------------------------------------------------
  // interrupt decode
  // ------------------------------------------------------------
  wire [7:0] events   = {3'h0, wr_blocked, cal_finish, sync_fall};
  wire [7:0] clr_bits = hit_stat ? reg_req.wdata : 8'h00;
  // a new event beats a write-one clear in the same cycle
  wire [7:0] next_status = (irq_status & ~clr_bits) | events;
  wire       irq_active  = |(irq_status & irq_mask);
  wire       pol      = interrupt_pin_config[`INT_POL_BIT];
  wire       next_pin_out =
    interrupt_pin_config[`INT_GPO_BIT] ? pol
                                       : (irq_active ? pol : !pol);
  wire       next_pin_oe =
    interrupt_pin_config[`INT_GPO_BIT] ||
    !interrupt_pin_config[`INT_TRI_BIT] || irq_active;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  // configuration registers, gated by the protection decode
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_sampling_phase  <= `RST_SYNC_PHASE;
      interrupt_pin_config <= `RST_INT_CFG;
      irq_mask             <= 8'h00;
      ofs_target           <= 16'h0000;
    end else begin
      if (hit_phase) sync_sampling_phase  <= reg_req.wdata;
      if (hit_int)   interrupt_pin_config <= reg_req.wdata;
      if (hit_mask)  irq_mask             <= reg_req.wdata;
      if (hit_lo)    ofs_target[7:0]      <= reg_req.wdata;
      if (hit_hi)    ofs_target[15:8]     <= reg_req.wdata;
    end
  end

  // start bit clears itself when the routine ends
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_monitor_config <= `RST_SYNC_MON;
    end else if (hit_mon) begin
      sync_monitor_config <= reg_req.wdata;
    end else if (cal_finish) begin
      sync_monitor_config[`MON_CAL_BIT] <= 1'b0;
    end
  end

  // single-shot key falls back to a locked code after one write
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      write_protection_key <= `RST_PROT_KEY;
    end else if (key_sel) begin
      write_protection_key <= reg_req.wdata;
    end else if (wr_ok && write_protection_key == `KEY_SINGLE) begin
      write_protection_key <= `KEY_RELOCK;
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= reg_req.rd ? rd_mux : 8'h00;
    end
  end

  // ------------------------------------------------------------
  // sync inputs: three-stage capture, agreement filter, history
  // ------------------------------------------------------------
  // only the second stage reads the first; a change is taken once the
  // second and third stages agree
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_s1  <= 3'h0;
      sync_s2  <= 3'h0;
      sync_s3  <= 3'h0;
      sync_flt <= 3'h0;
    end else begin
      sync_s1  <= sync_pin;
      sync_s2  <= sync_s1;
      sync_s3  <= sync_s2;
      sync_flt <= (sync_s2 & sync_s3) | (sync_flt & (sync_s2 ^ sync_s3));
    end
  end

  // history of each filtered input, one bit per system clock
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (sys_rst) begin
        hist[i] <= '0;
      end else begin
        hist[i] <= {hist[i][`HIST_LEN-2:0], sync_flt[i]};
      end
    end
  end

  // reference clock divider: the tick marks its falling edge
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ref_cnt  <= 4'h0;
      ref_tick <= 1'b0;
    end else begin
      ref_cnt  <= (ref_cnt == 4'(`UI_CYCLES - 1)) ? 4'h0
                                                  : ref_cnt + 4'h1;
      ref_tick <= (ref_cnt == 4'(`UI_CYCLES - 1));
    end
  end

  // sample each input at the tap its offset code selects
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync_sampled <= 3'h0;
    end else if (ref_tick) begin
      sync_sampled <= next_sampled;
    end
  end

  // ------------------------------------------------------------
  // phase offset ramp and calibration routine
  // ------------------------------------------------------------
  // one step per UI keeps every change gradual; the routine reuses
  // the same ramp so no step shows outside
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      applied_offset <= 16'h0000;
    end else if (ramp_en) begin
      applied_offset <= step(applied_offset, ramp_goal);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cal_state     <= sync_irq_protect_pkg::CAL_IDLE;
      holdover      <= 1'b0;
      divider_reset <= 1'b0;
    end else begin
      divider_reset <= 1'b0;
      case (cal_state)
        sync_irq_protect_pkg::CAL_IDLE: begin
          if (cal_start) begin
            cal_state <= sync_irq_protect_pkg::CAL_DOWN;
            holdover  <= 1'b1;
          end
        end
        sync_irq_protect_pkg::CAL_DOWN: begin
          if (applied_offset == 16'h0000) begin
            cal_state     <= sync_irq_protect_pkg::CAL_RESET;
            divider_reset <= 1'b1;
          end
        end
        sync_irq_protect_pkg::CAL_RESET: begin
          cal_state <= sync_irq_protect_pkg::CAL_UP;
        end
        sync_irq_protect_pkg::CAL_UP: begin
          if (cal_finish) begin
            cal_state <= sync_irq_protect_pkg::CAL_IDLE;
            holdover  <= 1'b0;
          end
        end
        default: begin
          cal_state <= sync_irq_protect_pkg::CAL_IDLE;
          holdover  <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupt status and pin
  // ------------------------------------------------------------
  // irq and pin lag the status by one cycle so all outputs are flops
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq_status  <= 8'h00;
      irq         <= 1'b0;
      irq_pin_out <= 1'b0;
      irq_pin_oe  <= 1'b0;
    end else begin
      irq_status  <= next_status;
      irq         <= irq_active;
      irq_pin_out <= next_pin_out;
      irq_pin_oe  <= next_pin_oe;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_EARLY_TAP: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    ref_tick && sync_sampling_phase[5:4] == 2'b01 |=>
      sync_sampled[2] == $past(sync_flt[2], 2))
    else $error("early sample tap wrong");
  AST_TARGET_TAP: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    ref_tick && sync_sampling_phase[1:0] == 2'b00 |=>
      sync_sampled[0] == $past(sync_flt[0], 6))
    else $error("on-target sample tap wrong");
  AST_RAMP_STEP: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !$stable(applied_offset) |-> $past(ref_tick) &&
      (applied_offset - $past(applied_offset) == 16'h0001 ||
       $past(applied_offset) - applied_offset == 16'h0001))
    else $error("offset jumped");
  // the shortest routine (offset already zero) still holds three cycles
  AST_CAL_SEQ: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    cal_start |=> holdover [*3])
    else $error("calibration left holdover early");
  AST_DIV_ZERO: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    divider_reset |-> holdover && applied_offset == 16'h0000)
    else $error("divider reset with offset applied");
  AST_GPO: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    interrupt_pin_config[2] |=>
      irq_pin_oe && irq_pin_out == $past(interrupt_pin_config[0]))
    else $error("general output not driven at polarity");
  // any write but the key, while locked, leaves phase, pin config, mask and offset target alone
  AST_LOCKED: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    reg_req.wr && reg_req.addr != `ADDR_PROT_KEY &&
      write_protection_key != `KEY_FULL &&
      write_protection_key != `KEY_SINGLE |=>
      $stable(sync_sampling_phase) && $stable(interrupt_pin_config) &&
      $stable(irq_mask) && $stable(ofs_target))
    else $error("write accepted while protected");
  AST_TRISTATE: assert property (@(posedge sys_clk)
    disable iff (sys_rst)
    !interrupt_pin_config[2] && interrupt_pin_config[1] && !irq_active
      |=> !irq_pin_oe)
    else $error("pin driven while idle in tristate mode");
  COV_CAL: cover property (@(posedge sys_clk) disable iff (sys_rst)
    cal_finish);
  COV_SINGLE: cover property (@(posedge sys_clk) disable iff (sys_rst)
    wr_ok && write_protection_key == `KEY_SINGLE);
  COV_IRQ: cover property (@(posedge sys_clk) disable iff (sys_rst)
    irq && irq_pin_oe);

endmodule

`default_nettype wire

// ===== bench/sync_irq_far_end.sv
// far side of the block: backplane sync sources and the host irq line
// assumes: one clock shared with the block, levels requested by the bench
`timescale 1ns/1ps
`default_nettype none

module sync_irq_far_end (
  input  wire logic       sys_clk,
  input  wire logic [2:0] sync_req,
  input  wire logic       irq_pin_out,
  input  wire logic       irq_pin_oe,
  output logic      [2:0] sync_pin,
  output logic            irq_wire
);
  // ----------------------------------------------------------------
  // backplane sync drivers
  // ----------------------------------------------------------------
  // sources change just after an edge, like real backplane logic
  always @(posedge sys_clk) begin
    sync_pin <= sync_req;
  end

  // ----------------------------------------------------------------
  // host interrupt input
  // ----------------------------------------------------------------
  // shared line with a pull-up, so an undriven pin reads high
  assign irq_wire = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule
`default_nettype wire

// ===== bench/sync_irq_protect_regs_test.sv
// self-checking bench for the sync sampling, irq pin and protection regs
// assumes: package, header, design and far-end model compiled first
`include "sync_irq_protect_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module sync_irq_protect_regs_test;
  logic                           sys_clk;
  logic                           sys_rst;
  sync_irq_protect_pkg::reg_req_s reg_req;
  logic [7:0]                     rd_data;
  logic [2:0]                     sync_req;
  logic [2:0]                     sync_pin;
  logic [2:0]                     sync_sampled;
  logic [15:0]                    applied_offset;
  logic                           holdover;
  logic                           divider_reset;
  logic                           irq;
  logic                           irq_pin_out;
  logic                           irq_pin_oe;
  logic                           irq_wire;
  logic [15:0]                    prev_ofs;
  int                             n_errors;
  int                             num_checks;
  int                             cyc;

  sync_irq_protect_regs dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .rd_data(rd_data), .sync_pin(sync_pin), .sync_sampled(sync_sampled),
    .applied_offset(applied_offset), .holdover(holdover),
    .divider_reset(divider_reset), .irq(irq),
    .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe));

  sync_irq_far_end far (
    .sys_clk(sys_clk), .sync_req(sync_req), .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe), .sync_pin(sync_pin), .irq_wire(irq_wire));

  // ----------------------------------------------------------------
  // clock, timeout and offset step watch
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // a jump of more than one LSB would be a visible phase hit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    prev_ofs <= applied_offset;
    if (!sys_rst && applied_offset !== prev_ofs &&
        applied_offset !== prev_ofs + 16'h0001 &&
        applied_offset !== prev_ofs - 16'h0001) begin
      $display("MISMATCH offset step expected 1 seen %h", applied_offset);
      n_errors++;
    end
    if (cyc == 20000) begin
      n_errors++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (n_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) reg_req <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) reg_req <= '0;
    #1 chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rd_data});
  endtask

  // irq and pin each lag their cause by one flop
  task automatic settle;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(`ADDR_SYNC_PHASE, `RST_SYNC_PHASE);
    rd_chk(`ADDR_SYNC_MON, `RST_SYNC_MON);
    rd_chk(`ADDR_INT_CFG, `RST_INT_CFG);
    rd_chk(`ADDR_PROT_KEY, `RST_PROT_KEY);
    rd_chk(8'h00, 8'h00);
    @(posedge sys_clk) #1 chk("rd_data idle", 16'h0000, rd_data);
    chk("idle pin oe/wire", 16'h0001, {irq_pin_oe, irq_wire});
  endtask

  task automatic t_protect;
    wr(`ADDR_PROT_KEY, `KEY_RELOCK);
    wr(`ADDR_INT_CFG, 8'h05);
    rd_chk(`ADDR_INT_CFG, `RST_INT_CFG);
    rd_chk(`ADDR_IRQ_STATUS, 8'h10);
    wr(`ADDR_PROT_KEY, `KEY_SINGLE);
    wr(`ADDR_INT_CFG, 8'h00);
    wr(`ADDR_INT_CFG, 8'h05);
    rd_chk(`ADDR_INT_CFG, 8'h00);
    rd_chk(`ADDR_PROT_KEY, `KEY_RELOCK);
    wr(`ADDR_PROT_KEY, `KEY_FULL);
    wr(`ADDR_INT_CFG, `RST_INT_CFG);
    rd_chk(`ADDR_INT_CFG, `RST_INT_CFG);
  endtask

  task automatic t_irq;
    settle;
    chk("irq masked", 16'h0000, irq);
    wr(`ADDR_IRQ_MASK, 8'h10);
    settle;
    chk("irq/oe/wire low", 16'h0006, {irq, irq_pin_oe, irq_wire});
    wr(`ADDR_INT_CFG, 8'h03);
    settle;
    chk("oe/wire high-active", 16'h0003, {irq_pin_oe, irq_wire});
    wr(`ADDR_IRQ_STATUS, 8'h10);
    settle;
    chk("cleared irq/oe", 16'h0000, {irq, irq_pin_oe});
    wr(`ADDR_INT_CFG, 8'h01);
    settle;
    chk("driven idle oe/out", 16'h0002, {irq_pin_oe, irq_pin_out});
    wr(`ADDR_INT_CFG, 8'h04);
    settle;
    chk("gpo low oe/out", 16'h0002, {irq_pin_oe, irq_pin_out});
    wr(`ADDR_INT_CFG, 8'h05);
    settle;
    chk("gpo high oe/out", 16'h0003, {irq_pin_oe, irq_pin_out});
    wr(`ADDR_INT_CFG, `RST_INT_CFG);
    wr(`ADDR_IRQ_MASK, 8'h00);
  endtask

  // drop all three sync pins at a fixed tick phase, count to each fall
  task automatic sync_trial(input logic [7:0] cfg, output int l [3]);
    logic [2:0] seen;
    wr(`ADDR_SYNC_PHASE, cfg);
    sync_req <= 3'b111;
    repeat (40) @(posedge sys_clk);
    #1 chk("sync idle high", 16'h0007, sync_sampled);
    @(posedge sys_clk);
    while (cyc % 8 != 0) @(posedge sys_clk);
    sync_req <= 3'b000;
    seen = 3'b000;
    l = '{-1, -1, -1};
    for (int n = 1; n <= 64; n++) begin
      @(posedge sys_clk) #1;
      for (int i = 0; i < 3; i++) begin
        if (!seen[i] && sync_sampled[i] === 1'b0) begin
          l[i] = n;
          seen[i] = 1'b1;
        end
      end
    end
  endtask

  // codes 01/00/11 then 11/10/01: each pair of taps is one UI apart
  task automatic t_sync;
    int a [3];
    int b [3];
    sync_trial(8'h31, a);
    sync_trial(8'h1B, b);
    chk("ch0 late half vs early", 16'd8, 16'(b[0] - a[0]));
    chk("ch1 late one vs target", 16'd8, 16'(b[1] - a[1]));
    chk("ch2 late half vs early", 16'd8, 16'(a[2] - b[2]));
    chk("early<=target<=late", 16'h0001,
        16'(a[0] > 0 && a[0] <= a[1] && a[1] <= a[2]));
    rd_chk(`ADDR_IRQ_STATUS, 8'h07);
    wr(`ADDR_IRQ_STATUS, 8'h07);
  endtask

  task automatic t_ramp;
    wr(`ADDR_OFS_LO, 8'h03);
    repeat (12) @(posedge sys_clk);
    #1 chk("ramp midway", 16'h0001,
           16'(applied_offset inside {16'h0001, 16'h0002}));
    repeat (30) @(posedge sys_clk);
    #1 chk("ramp end", 16'h0003, applied_offset);
    rd_chk(`ADDR_APPLIED_LO, 8'h03);
  endtask

  task automatic t_cal;
    int pulses;
    logic zero_seen;
    pulses = 0;
    zero_seen = 1'b0;
    wr(`ADDR_SYNC_MON, 8'hAB);
    @(posedge sys_clk) #1 chk("holdover on", 16'h0001, holdover);
    for (int n = 0; n < 200 && holdover === 1'b1; n++) begin
      @(posedge sys_clk) #1;
      if (applied_offset === 16'h0000) zero_seen = 1'b1;
      if (divider_reset === 1'b1) begin
        pulses++;
        chk("reset at zero", 16'h0000, applied_offset);
      end
    end
    chk("holdover/zero/pulses", 16'h0011,
        {7'h00, holdover, 3'h0, zero_seen, 4'(pulses)});
    chk("offset restored", 16'h0003, applied_offset);
    rd_chk(`ADDR_SYNC_MON, `RST_SYNC_MON);
    rd_chk(`ADDR_IRQ_STATUS, 8'h08);
    wr(`ADDR_IRQ_MASK, 8'h08);
    settle;
    chk("irq cal done", 16'h0001, irq);
    wr(`ADDR_IRQ_STATUS, 8'h08);
    settle;
    chk("irq cleared", 16'h0000, irq);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    reg_req = '0;
    sync_req = 3'b111;
    prev_ofs = 16'h0000;
    n_errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_protect();
    t_irq();
    t_sync();
    t_ramp();
    t_cal();
    final_report();
  end
endmodule
`default_nettype wire
